// >>> hw/mpss_sequencer.v
/*
 * Multiphase PWM start-up sequencer: channel-count detection, evenly
 * spaced phases, power-on-reset three-state, soft-start ramp, power-good
 * hold-off, current balancing and overcurrent restart.
 * Assumes asynchronous pin inputs (por, sense levels, comparators) and
 * external gate drivers resolving each output from its enable.
 */
`timescale 1ns/100ps
`include "mpss_regs.vh"

// Notes on behaviour
// - Up to four PWM channels, each with own output and current trim.
// - Outputs three and four held high by board are inactive; channel count derived from them.
// - Active outputs phase shifted by 360 degrees over active channel count.
// - While power-on reset is asserted, outputs three-stated, state initialised.
// - Release of power-on reset starts soft-start; outputs enabled after cycle 32.
// - Reasserted power-on reset shuts down and three-states every output.
// - First 32 switching cycles: reference inhibited, outputs three-stated.
// - From cycle 33 for about 150 cycles all active outputs driven low.
// - Then duty ramps from zero up to the operating pulse width.
// - Reference rises slowly from zero, paced by switching cycles.
// - Power-good stays low until the 2048th switching cycle.
// - Total soft-start delay equals 2048 switching periods.
// - Channel above average current gets a shorter pulse.
// - Outputs non-inverting: larger duty gives longer high pulse.
// - Overcurrent during start-up restarts soft-start from the beginning.
// - Power-good only with core voltage in limits and soft-start done.
module mpss_sequencer #(
    parameter PERIOD = 150,
    parameter DUTY_MAX = 120
)(
    input wire mclk_i,
    input wire sys_rst_i,
    input wire por_i,
    input wire phase_three_sense_i,
    input wire phase_four_sense_i,
    input wire [`MPSS_MAX_PHASES-1:0] over_average_i,
    input wire over_current_i,
    input wire core_in_limits_i,
    output reg [`MPSS_MAX_PHASES-1:0] pwm_o,
    output reg [`MPSS_MAX_PHASES-1:0] pwm_oe_o,
    output reg [`MPSS_DUTY_WIDTH-1:0] reference_o,
    output reg power_ok_output,
    output reg [2:0] channel_count_o
);
    localparam [3:0] ST_HOLD = 4'h1;
    localparam [3:0] ST_TRI = 4'h2;
    localparam [3:0] ST_CLAMP = 4'h4;
    localparam [3:0] ST_RAMP = 4'h8;
    localparam [7:0] PER = PERIOD[7:0];
    localparam [7:0] DMAX = DUTY_MAX[7:0];

    reg [1:0] por_s;
    reg [1:0] p3_s;
    reg [1:0] p4_s;
    reg [1:0] oc_s;
    reg [1:0] ok_s;
    reg [`MPSS_MAX_PHASES-1:0] oa_m;
    reg [`MPSS_MAX_PHASES-1:0] oa_s;
    reg [3:0] state;
    reg [7:0] saw;
    reg [`MPSS_CYCLE_WIDTH-1:0] cycles;
    reg [7:0] duty;
    reg [7:0] step;
    reg [7:0] off [0:`MPSS_MAX_PHASES-1];
    reg [`MPSS_MAX_PHASES-1:0] next_pwm;
    reg [7:0] pos;
    reg [7:0] lim;
    integer i;
    integer j;

    wire por = por_s[1];
    wire cycle_end = (saw == PER - 8'h01);

    always @(posedge mclk_i)
    begin
        por_s <= {por_s[0], por_i};
        p3_s <= {p3_s[0], phase_three_sense_i};
        p4_s <= {p4_s[0], phase_four_sense_i};
        oc_s <= {oc_s[0], over_current_i};
        ok_s <= {ok_s[0], core_in_limits_i};
        oa_m <= over_average_i;
        oa_s <= oa_m;
    end

    always @*
    begin
        case (channel_count_o)
            3'h2: step = PER >> 1;
            3'h3: step = PER / 8'h03;
            default: step = PER >> 2;
        endcase
    end

    always @*
    begin
        next_pwm = {`MPSS_MAX_PHASES{1'b0}};
        pos = 8'h00;
        lim = 8'h00;
        for (i = 0; i < `MPSS_MAX_PHASES; i = i + 1)
        begin
            pos = (saw >= off[i]) ? saw - off[i] : saw + PER - off[i];
            lim = (oa_s[i] && duty > 8'h04) ? duty - 8'h04 : duty;
            next_pwm[i] = (pos < lim);
        end
    end

    always @(posedge mclk_i)
    begin
        if (sys_rst_i)
        begin
            state <= ST_HOLD;
            saw <= 8'h00;
            cycles <= {`MPSS_CYCLE_WIDTH{1'b0}};
            duty <= 8'h00;
            pwm_o <= {`MPSS_MAX_PHASES{1'b0}};
            pwm_oe_o <= {`MPSS_MAX_PHASES{1'b0}};
            reference_o <= 8'h00;
            power_ok_output <= 1'b0;
            channel_count_o <= 3'h4;
            for (j = 0; j < `MPSS_MAX_PHASES; j = j + 1)
                off[j] <= 8'h00;
        end
        else if (por)
        begin
            state <= ST_HOLD;
            saw <= 8'h00;
            cycles <= {`MPSS_CYCLE_WIDTH{1'b0}};
            duty <= 8'h00;
            pwm_o <= {`MPSS_MAX_PHASES{1'b0}};
            pwm_oe_o <= {`MPSS_MAX_PHASES{1'b0}};
            reference_o <= 8'h00;
            power_ok_output <= 1'b0;
            channel_count_o <= p3_s[1] ? 3'h2 : (p4_s[1] ? 3'h3 : 3'h4);
        end
        else
        begin
            saw <= cycle_end ? 8'h00 : saw + 8'h01;
            for (j = 0; j < `MPSS_MAX_PHASES; j = j + 1)
                off[j] <= step * j[7:0];
            power_ok_output <= (cycles == `MPSS_SOFT_START_CYCLES) && ok_s[1];
            case (state)
                ST_HOLD:
                begin
                    state <= ST_TRI;
                    saw <= 8'h00;
                end
                ST_TRI:
                begin
                    pwm_oe_o <= {`MPSS_MAX_PHASES{1'b0}};
                    reference_o <= 8'h00;
                    if (cycle_end)
                    begin
                        cycles <= cycles + 12'h001;
                        if (cycles == `MPSS_TRISTATE_CYCLES - 12'h001)
                            state <= ST_CLAMP;
                    end
                end
                ST_CLAMP:
                begin
                    pwm_o <= {`MPSS_MAX_PHASES{1'b0}};
                    pwm_oe_o <= active_mask(channel_count_o);
                    if (cycle_end)
                    begin
                        cycles <= cycles + 12'h001;
                        if (cycles == `MPSS_CLAMP_END_CYCLES - 12'h001)
                            state <= ST_RAMP;
                    end
                end
                default:
                begin
                    pwm_oe_o <= active_mask(channel_count_o);
                    pwm_o <= next_pwm & active_mask(channel_count_o);
                    if (cycle_end)
                    begin
                        if (cycles != `MPSS_SOFT_START_CYCLES)
                            cycles <= cycles + 12'h001;
                        if (cycles[2:0] == 3'h7 && duty < DMAX)
                            duty <= duty + 8'h01;
                        if (cycles[2:0] == 3'h7 && reference_o != 8'hff)
                            reference_o <= reference_o + 8'h01;
                    end
                end
            endcase
            // Charging the output capacitors can trip overcurrent; a
            // restart keeps the inrush bounded instead of latching off.
            // overcurrent restarts start-up
            if (oc_s[1] && cycles != `MPSS_SOFT_START_CYCLES
                && state != ST_HOLD)
            begin
                state <= ST_HOLD;
                cycles <= {`MPSS_CYCLE_WIDTH{1'b0}};
                duty <= 8'h00;
                reference_o <= 8'h00;
                pwm_o <= {`MPSS_MAX_PHASES{1'b0}};
                pwm_oe_o <= {`MPSS_MAX_PHASES{1'b0}};
                power_ok_output <= 1'b0;
            end
        end
    end

    function [`MPSS_MAX_PHASES-1:0] active_mask;
        input [2:0] n;
        begin
            active_mask = (n == 3'h2) ? 4'h3 : ((n == 3'h3) ? 4'h7 : 4'hf);
        end
    endfunction
endmodule

// >>> shared/mpss_regs.vh
/*
 * Constants of the multiphase PWM start-up sequencer: maximum phase count, the
 * soft-start cycle milestones, the default period and the widths.
 * Assumes inclusion by the sequencer module only; definitions only.
 */
`ifndef MPSS_REGS_VH
`define MPSS_REGS_VH

`define MPSS_MAX_PHASES 4
`define MPSS_TRISTATE_CYCLES 12'h020
`define MPSS_CLAMP_END_CYCLES 12'h0b6
`define MPSS_SOFT_START_CYCLES 12'h800
`define MPSS_DEFAULT_PERIOD 8'h96
`define MPSS_DUTY_WIDTH 8
`define MPSS_CYCLE_WIDTH 12

`endif

// >>> verification/mpss_gate_drv.sv
/* Gate driver inputs of phases three and four, as the sequencer sees them.
   Assumes board straps; a released driver input is biased low. */
`timescale 1ns/100ps
module mpss_gate_drv (
    input wire logic strap3_i,
    input wire logic strap4_i,
    input wire logic [3:0] pwm_i,
    input wire logic [3:0] oe_i,
    output wire logic sense3_o,
    output wire logic sense4_o
);
    assign sense3_o = strap3_i | (oe_i[2] & pwm_i[2]);
    assign sense4_o = strap4_i | (oe_i[3] & pwm_i[3]);
endmodule

// >>> verification/mpss_seq_asserts.sv
/* Port checker of the start-up sequencer.
   Assumes a bind from the bench top and the design's PERIOD value. */
`timescale 1ns/100ps
module mpss_seq_asserts #(parameter int PERIOD = 150) (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic por_i,
    input wire logic phase_three_sense_i,
    input wire logic over_current_i,
    input wire logic core_in_limits_i,
    input wire logic [3:0] pwm_o,
    input wire logic [3:0] pwm_oe_o,
    input wire logic [7:0] reference_o,
    input wire logic power_ok_output,
    input wire logic [2:0] channel_count_o
);
    int clk_n;
    always @(posedge mclk_i)
    begin
        if (sys_rst_i || por_i)
            clk_n <= 0;
        else
            clk_n <= clk_n + 1;
    end
    default clocking @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);
    sequence por_held;
        por_i [*4];
    endsequence
    por_tri_a: assert property (por_held |-> pwm_oe_o == 4'h0 &&
        reference_o == 8'h00 && !power_ok_output) else $error("active in por");
    por_drop_a: assert property ($rose(por_i) |-> ##[1:5]
        pwm_oe_o == 4'h0) else $error("no three-state on por");
    idle_lines_a: assert property (
        (pwm_oe_o >> channel_count_o) == 4'h0) else $error("idle line driven");
    count_latch_a: assert property ((por_i && phase_three_sense_i) [*5]
        |-> channel_count_o == 3'h2) else $error("count not latched");
    clamp_low_a: assert property ($rose(|pwm_oe_o) |->
        (pwm_o == 4'h0) [*8]) else $error("clamp not low");
    power_ok_output_delay_a: assert property ($rose(power_ok_output) |->
        clk_n >= 2048 * PERIOD) else $error("power ok early");
    power_ok_output_core_a: assert property (!core_in_limits_i [*4] |->
        !power_ok_output) else $error("power ok out of limits");
    tri_hold_a: assert property ($rose(|pwm_oe_o) |->
        clk_n >= 32 * PERIOD) else $error("clamp before tri end");
    ramp_late_a: assert property ($rose(|pwm_o) |->
        clk_n >= 182 * PERIOD) else $error("drive before clamp end");
    oc_restart_a: assert property (
        (over_current_i && clk_n < 2000 * PERIOD) [*4] |-> ##[0:4]
        pwm_oe_o == 4'h0) else $error("no restart on overcurrent");
endmodule

// >>> verification/testbench.sv
/* Self-checking bench of the start-up sequencer, period shortened to 20.
   Assumes the gate driver model and the checker beside it. */
`timescale 1ns/100ps
module testbench;
    localparam int PER = 20;
    localparam int DMAX = 12;
    logic mclk = 1'b0, rst = 1'b1, por = 1'b1, oc = 1'b0, core = 1'b1;
    logic u3 = 1'b0, u4 = 1'b0, oe_seen = 1'b0, rnd = 1'b1;
    logic [3:0] avg = 4'h0;
    logic [6:0] notes[$];
    wire s3, s4, pok;
    wire [3:0] pwm, oe;
    wire [2:0] cnt;
    wire [7:0] ref_code;
    int fails = 0, total_checks = 0, gap = 0;
    int at[4], wid[4];
    always #10 mclk = ~mclk;
    mpss_sequencer #(.PERIOD(PER), .DUTY_MAX(DMAX)) dut_u (.mclk_i(mclk),
        .sys_rst_i(rst), .por_i(por), .phase_three_sense_i(s3),
        .phase_four_sense_i(s4), .over_average_i(avg), .over_current_i(oc),
        .core_in_limits_i(core), .pwm_o(pwm), .pwm_oe_o(oe),
        .reference_o(ref_code), .power_ok_output(pok), .channel_count_o(cnt));
    mpss_gate_drv drv_u (.strap3_i(u3), .strap4_i(u4), .pwm_i(pwm),
        .oe_i(oe), .sense3_o(s3), .sense4_o(s4));
    task check(input string nm, input logic [7:0] seen, exp);
        total_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task wait_for(input int lim, input bit want_ok);
        for (int i = 0; i < lim; i++)
        begin
            tick(1);
            if (want_ok ? pok === 1'b1 : (|oe) === 1'b1)
                return;
        end
        fails++;
        $display("unexpected wait expected done seen timeout");
        test_done();
    endtask
    // Records, over three switching periods, the first rising edge of
    // every phase output and the length of that pulse, in clocks.
    task scan;
        logic [3:0] last;
        last = 4'hf;
        for (int c = 0; c < 4; c++)
        begin
            at[c] = -1;
            wid[c] = 0;
        end
        for (int i = 0; i < 60; i++)
        begin
            tick(1);
            for (int c = 0; c < 4; c++)
            begin
                if (pwm[c] === 1'b1 && !last[c] && at[c] < 0)
                    at[c] = i;
                if (pwm[c] === 1'b1 && at[c] >= 0 && wid[c] == i - at[c])
                    wid[c]++;
            end
            last = pwm;
        end
    endtask
    // Sampled away from the launching edge so the outputs have settled.
    always @(negedge mclk)
    begin
        oe_seen <= |oe;
        if ((|oe) && !oe_seen)
            check("mask", {1'b0, cnt, oe}, {1'b0, notes.pop_front()});
    end
    initial
    begin
        void'($urandom(32'he7aec05a));
        fork
            forever
            begin
                @(posedge mclk);
                #1 avg = rnd ? 4'($urandom) : 4'h2;
            end
        join_none
        tick(2);
        rst = 1'b0;
        for (int k = 2; k <= 4; k++)
        begin
            por = 1'b1;
            u3 = (k == 2);
            u4 = (k < 4);
            tick(8);
            notes.push_back({k[2:0], 4'hf >> (4 - k)});
            por = 1'b0;
            wait_for(5000, 1'b0);
            check("ref_tri", ref_code, 8'h00);
            if (k == 3)
            begin
                oc = 1'b1;
                tick(9);
                check("oe_oc", {4'h0, oe}, 8'h00);
                oc = 1'b0;
            end
            $display("test count %0d done", k);
        end
        wait_for(45000, 1'b1);
        check("pok", {7'h00, pok}, 8'h01);
        check("ref_up", {7'h00, ref_code != 8'h00}, 8'h01);
        rnd = 1'b0;
        tick(5);
        scan();
        for (int c = 1; c < 4; c++)
        begin
            gap = (at[c] - at[0] + PER) % PER;
            check("phase", 8'(gap), 8'(c * PER / 4));
        end
        check("width", 8'(wid[0]), 8'(DMAX));
        check("trim", 8'(wid[1]), 8'(DMAX - 4));
        $display("test pulse shape done");
        core = 1'b0;
        tick(6);
        check("pok_core", {7'h00, pok}, 8'h00);
        por = 1'b1;
        tick(6);
        check("oe_por", {4'h0, oe}, 8'h00);
        $display("test power ok done");
        test_done();
    end
endmodule
bind mpss_sequencer mpss_seq_asserts #(.PERIOD(PERIOD)) chk_u (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .por_i(por_i),
    .phase_three_sense_i(phase_three_sense_i), .over_current_i(over_current_i),
    .core_in_limits_i(core_in_limits_i), .pwm_o(pwm_o), .pwm_oe_o(pwm_oe_o),
    .reference_o(reference_o), .power_ok_output(power_ok_output),
    .channel_count_o(channel_count_o));
